// >>> pacr_map.vh
// register map and codes for the port assignment configuration bank
`ifndef PACR_MAP_VH
`define PACR_MAP_VH

// register indexes; byte address is four times the index
`define PACR_IDX_S1_P34   8'hd6
`define PACR_IDX_S1_SPC   8'hd7
`define PACR_IDX_S1_SPD   8'hd8
`define PACR_IDX_S2_P12   8'hd9
`define PACR_IDX_S2_P34   8'hda
`define PACR_IDX_S2_SPC   8'hdb
`define PACR_IDX_S2_SPD   8'hdc

// index field inside the apb byte address
`define PACR_IDX_MSB      9
`define PACR_IDX_LSB      2
`define PACR_ALIGN_MSB    1
`define PACR_ALIGN_LSB    0
`define PACR_ALIGN_OK     2'h0

// assignment byte layout
`define PACR_HI_MSB       7
`define PACR_HI_LSB       4
`define PACR_LO_MSB       3
`define PACR_LO_LSB       0
`define PACR_BYTE_MSB     7
`define PACR_BYTE_LSB     0
`define PACR_BYTE_RST     8'h00
`define PACR_STRB_LANE0   0

// owner codes
`define PACR_CODE_NONE    4'h0
`define PACR_CODE_FIRST   4'h1
`define PACR_CODE_SECOND  4'h2

// decoded route: bit 0 first upstream host, bit 1 second
`define PACR_ROUTE_NONE   2'h0
`define PACR_ROUTE_FIRST  2'h1
`define PACR_ROUTE_SECOND 2'h2

`define PACR_DATA_ZERO    32'h0000_0000

`endif

// >>> pacr_regs.v
// apb register bank for downstream port ownership, sets 1 and 2
//
// The APB register port was left to the implementer.
`timescale 1ns/10ps
`include "pacr_map.vh"

// owner code to route decode
module pacr_owner_dec
(
   input  wire [3:0] code,
   output reg  [1:0] route
);

   always @*
   begin
      case (code)
         `PACR_CODE_NONE:
         begin
            route = `PACR_ROUTE_NONE;
         end
         `PACR_CODE_FIRST:
         begin
            route = `PACR_ROUTE_FIRST;
         end
         `PACR_CODE_SECOND:
         begin
            route = `PACR_ROUTE_SECOND;
         end
         default:
         begin
            // reserved codes fall back to the first host
            route = `PACR_ROUTE_FIRST;
         end
      endcase
   end

endmodule

// one owner byte: loads on a completed write, clears on reset
module pacr_owner_byte
#(
   parameter             WIDTH   = 8,
   parameter [WIDTH-1:0] RST_VAL = `PACR_BYTE_RST
)
(
   input  wire             pclk,
   input  wire             presetn,
   input  wire             load,
   input  wire [WIDTH-1:0] wdata,
   output reg  [WIDTH-1:0] value
);

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         value <= RST_VAL;
      end
      else if (load)
      begin
         value <= wdata;
      end
   end

endmodule

// Functional notes
// - set 1 byte at D6h: high nibble owns port 4, low nibble port 3.
// - set 2 byte at D9h: high nibble owns port 2, low nibble port 1.
// - set 2 byte at DAh: high nibble owns port 4, low nibble port 3.
// - owner code 0000 unassigned, 0001 first host, 0010 second host.
// - owner codes 0011 to 1111 behave exactly like 0001.
// - bytes D7h, D8h, DBh, DCh read zero and never affect ownership.
// - all assignment bytes of sets 1 and 2 reset to 0x00.
module pacr_regs
(
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [9:0]  paddr,
   input  wire [31:0] pwdata,
   input  wire [3:0]  pstrb,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   output reg  [1:0]  set1_port3_route,
   output reg  [1:0]  set1_port4_route,
   output reg  [1:0]  set2_port1_route,
   output reg  [1:0]  set2_port2_route,
   output reg  [1:0]  set2_port3_route,
   output reg  [1:0]  set2_port4_route
);

   wire [7:0]  set1_ports34_owner;
   wire [7:0]  set2_ports12_owner;
   wire [7:0]  set2_ports34_owner;

   wire [7:0]  addr_idx;
   wire        addr_aligned;
   wire        hit_s1_p34;
   wire        hit_s2_p12;
   wire        hit_s2_p34;
   wire        hit_spare;
   wire        mapped;
   wire        access;
   wire        complete;
   wire        wr_lane0;
   wire        ld_s1_p34;
   wire        ld_s2_p12;
   wire        ld_s2_p34;

   reg  [7:0]  rd_byte;
   reg  [31:0] next_prdata;
   reg         next_pready;
   reg         next_pslverr;

   wire [1:0]  dec_s1_p3;
   wire [1:0]  dec_s1_p4;
   wire [1:0]  dec_s2_p1;
   wire [1:0]  dec_s2_p2;
   wire [1:0]  dec_s2_p3;
   wire [1:0]  dec_s2_p4;

   // address decode
   assign addr_idx     = paddr[`PACR_IDX_MSB:`PACR_IDX_LSB];
   assign addr_aligned = (paddr[`PACR_ALIGN_MSB:`PACR_ALIGN_LSB]
                          == `PACR_ALIGN_OK);

   assign hit_s1_p34 = addr_aligned
                       && (addr_idx == `PACR_IDX_S1_P34);
   assign hit_s2_p12 = addr_aligned
                       && (addr_idx == `PACR_IDX_S2_P12);
   assign hit_s2_p34 = addr_aligned
                       && (addr_idx == `PACR_IDX_S2_P34);

   assign hit_spare  = addr_aligned
                       && ((addr_idx == `PACR_IDX_S1_SPC)
                        || (addr_idx == `PACR_IDX_S1_SPD)
                        || (addr_idx == `PACR_IDX_S2_SPC)
                        || (addr_idx == `PACR_IDX_S2_SPD));

   assign mapped = hit_s1_p34 || hit_s2_p12 || hit_s2_p34 || hit_spare;

   // one wait state: pready rises in the second access cycle
   assign access   = psel && penable;
   assign complete = access && pready;
   assign wr_lane0 = complete && pwrite && mapped
                     && pstrb[`PACR_STRB_LANE0];

   // read mux; spare bytes have no storage at all
   always @*
   begin
      rd_byte = `PACR_BYTE_RST;
      if (hit_s1_p34)
      begin
         rd_byte = set1_ports34_owner;
      end
      else if (hit_s2_p12)
      begin
         rd_byte = set2_ports12_owner;
      end
      else if (hit_s2_p34)
      begin
         rd_byte = set2_ports34_owner;
      end
      else
      begin
         rd_byte = `PACR_BYTE_RST;
      end
   end

   // answer prepared in the first access cycle
   always @*
   begin
      next_prdata  = `PACR_DATA_ZERO;
      next_pready  = 1'b0;
      next_pslverr = 1'b0;
      if (access && !pready)
      begin
         next_pready  = 1'b1;
         next_pslverr = !mapped;
         if (!pwrite)
         begin
            next_prdata = {24'h00_0000, rd_byte};
         end
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= `PACR_DATA_ZERO;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         prdata  <= next_prdata;
         pready  <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // writes land on the edge that completes the transfer
   assign ld_s1_p34 = wr_lane0 && hit_s1_p34;
   assign ld_s2_p12 = wr_lane0 && hit_s2_p12;
   assign ld_s2_p34 = wr_lane0 && hit_s2_p34;
   // spare hits get no load strobe: data is dropped

   // owner storage; spare bytes have none, so they cannot drift
   pacr_owner_byte
   #(
      .RST_VAL (`PACR_BYTE_RST)
   )
   u_own_s1_p34
   (
      .pclk    (pclk),
      .presetn (presetn),
      .load    (ld_s1_p34),
      .wdata   (pwdata[`PACR_BYTE_MSB:`PACR_BYTE_LSB]),
      .value   (set1_ports34_owner)
   );

   pacr_owner_byte
   #(
      .RST_VAL (`PACR_BYTE_RST)
   )
   u_own_s2_p12
   (
      .pclk    (pclk),
      .presetn (presetn),
      .load    (ld_s2_p12),
      .wdata   (pwdata[`PACR_BYTE_MSB:`PACR_BYTE_LSB]),
      .value   (set2_ports12_owner)
   );

   pacr_owner_byte
   #(
      .RST_VAL (`PACR_BYTE_RST)
   )
   u_own_s2_p34
   (
      .pclk    (pclk),
      .presetn (presetn),
      .load    (ld_s2_p34),
      .wdata   (pwdata[`PACR_BYTE_MSB:`PACR_BYTE_LSB]),
      .value   (set2_ports34_owner)
   );

   pacr_owner_dec u_dec_s1_p3
   (
      .code  (set1_ports34_owner[`PACR_LO_MSB:`PACR_LO_LSB]),
      .route (dec_s1_p3)
   );

   pacr_owner_dec u_dec_s1_p4
   (
      .code  (set1_ports34_owner[`PACR_HI_MSB:`PACR_HI_LSB]),
      .route (dec_s1_p4)
   );

   pacr_owner_dec u_dec_s2_p1
   (
      .code  (set2_ports12_owner[`PACR_LO_MSB:`PACR_LO_LSB]),
      .route (dec_s2_p1)
   );

   pacr_owner_dec u_dec_s2_p2
   (
      .code  (set2_ports12_owner[`PACR_HI_MSB:`PACR_HI_LSB]),
      .route (dec_s2_p2)
   );

   pacr_owner_dec u_dec_s2_p3
   (
      .code  (set2_ports34_owner[`PACR_LO_MSB:`PACR_LO_LSB]),
      .route (dec_s2_p3)
   );

   pacr_owner_dec u_dec_s2_p4
   (
      .code  (set2_ports34_owner[`PACR_HI_MSB:`PACR_HI_LSB]),
      .route (dec_s2_p4)
   );

   // routes registered so outputs are glitch free; one cycle behind
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         set1_port3_route <= `PACR_ROUTE_NONE;
         set1_port4_route <= `PACR_ROUTE_NONE;
         set2_port1_route <= `PACR_ROUTE_NONE;
         set2_port2_route <= `PACR_ROUTE_NONE;
         set2_port3_route <= `PACR_ROUTE_NONE;
         set2_port4_route <= `PACR_ROUTE_NONE;
      end
      else
      begin
         set1_port3_route <= dec_s1_p3;
         set1_port4_route <= dec_s1_p4;
         set2_port1_route <= dec_s2_p1;
         set2_port2_route <= dec_s2_p2;
         set2_port3_route <= dec_s2_p3;
         set2_port4_route <= dec_s2_p4;
      end
   end

endmodule

// >>> pacr_regs_sva.sv
// assertions on the ownership bank ports
`timescale 1ns/10ps
module pacr_regs_sva
(
   input logic        pclk,
   input logic        presetn,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [9:0]  paddr,
   input logic [31:0] pwdata,
   input logic [3:0]  pstrb,
   input logic [31:0] prdata,
   input logic        pready,
   input logic [1:0]  set1_port3_route,
   input logic [1:0]  set1_port4_route,
   input logic [1:0]  set2_port1_route,
   input logic [1:0]  set2_port2_route,
   input logic [1:0]  set2_port3_route,
   input logic [1:0]  set2_port4_route
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire [11:0] rts = {set1_port4_route, set1_port3_route, set2_port4_route,
                      set2_port3_route, set2_port2_route, set2_port1_route};
   wire        rsv = paddr inside {10'h35c, 10'h360, 10'h36c, 10'h370};
   function automatic [3:0] d2(input [31:0] b);
      d2[3:2] = b[7:4] == 4'h0 ? 2'h0 : b[7:4] == 4'h2 ? 2'h2 : 2'h1;
      d2[1:0] = b[3:0] == 4'h0 ? 2'h0 : b[3:0] == 4'h2 ? 2'h2 : 2'h1;
   endfunction
   sequence s_wr(a);
      psel && penable && pready && pwrite && pstrb[0] && paddr == a;
   endsequence
   // routes may land one edge late, so look two edges on
   set1_p34_a: assert property
      (s_wr(10'h358) |-> ##2 rts[11:8] == d2($past(pwdata, 2)))
      else $error("set 1 port 3 4 route wrong");
   set2_p12_a: assert property
      (s_wr(10'h364) |-> ##2 rts[3:0] == d2($past(pwdata, 2)))
      else $error("set 2 port 1 2 route wrong");
   set2_p34_a: assert property
      (s_wr(10'h368) |-> ##2 rts[7:4] == d2($past(pwdata, 2)))
      else $error("set 2 port 3 4 route wrong");
   route_legal_a: assert property
      (!(|(rts & {rts[10:0], 1'b0} & 12'haaa)))
      else $error("route code 11 seen");
   rsvd_code_a: assert property
      (s_wr(10'h358) ##0 pwdata[3:0] > 4'h2 |-> ##2 set1_port3_route == 2'h1)
      else $error("reserved code not first host");
   spare_read_a: assert property
      (pready && !pwrite && rsv |-> prdata == 32'h0000_0000)
      else $error("spare byte reads nonzero");
   reset_routes_a: assert property ($rose(presetn) |-> rts == 12'h000)
      else $error("routes not clear after reset");
   spare_write_a: assert property
      (psel && penable && pready && pwrite && rsv |=> $stable(rts))
      else $error("spare write moved a route");
endmodule

// >>> pacr_tb.sv
// self-checking bench for the ownership bank
`timescale 1ns/10ps
module testbench;
   logic        pclk = 0;
   logic        presetn = 0;
   logic        psel = 0;
   logic        penable = 0;
   logic        pwrite = 0;
   logic [9:0]  paddr = '0;
   logic [31:0] pwdata = '0;
   logic [3:0]  pstrb = '0;
   wire  [31:0] prdata;
   wire         pready, pslverr;
   wire  [1:0]  set1_port3_route, set1_port4_route, set2_port1_route;
   wire  [1:0]  set2_port2_route, set2_port3_route, set2_port4_route;
   wire  [11:0] rts = {set1_port4_route, set1_port3_route, set2_port4_route,
                       set2_port3_route, set2_port2_route, set2_port1_route};
   logic [9:0]  rsv [4] = '{10'h35c, 10'h360, 10'h36c, 10'h370};
   int          n_errors = 0;
   int          checked = 0;
   logic [31:0] rd;
   logic        er;
   pacr_regs dut
   (
      .pclk             (pclk),
      .presetn          (presetn),
      .psel             (psel),
      .penable          (penable),
      .pwrite           (pwrite),
      .paddr            (paddr),
      .pwdata           (pwdata),
      .pstrb            (pstrb),
      .prdata           (prdata),
      .pready           (pready),
      .pslverr          (pslverr),
      .set1_port3_route (set1_port3_route),
      .set1_port4_route (set1_port4_route),
      .set2_port1_route (set2_port1_route),
      .set2_port2_route (set2_port2_route),
      .set2_port3_route (set2_port3_route),
      .set2_port4_route (set2_port4_route)
   );
   always #10 pclk = ~pclk;
   function automatic [1:0] own(input [3:0] c);
      own = c == 4'h0 ? 2'h0 : c == 4'h2 ? 2'h2 : 2'h1;
   endfunction
   task chk(input string nm, input [31:0] got, input [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected %s exp %h got %h", nm, exp, got);
      end
   endtask
   // idle edge first so psel is never driven twice in one step
   task apb(input w, input [9:0] a, input [31:0] d, input [3:0] s);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1;
      // no local limit: only the watchdog may end a hung wait
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task settle;
      repeat (2) @(posedge pclk);
      #1;
   endtask
   task t_reset;
      presetn <= 0;
      repeat (16) @(posedge pclk);
      presetn <= 1;
      #1;
      chk("routes", rts, 0);
      for (int i = 0; i < 7; i++)
      begin
         apb(0, 10'h358 + 10'(4 * i), 0, 0);
         chk("reset byte", rd, 0);
      end
   endtask
   task t_codes;
      for (int c = 0; c < 16; c++)
      begin
         apb(1, 10'h358, {24'h00_0000, c[3:0], ~c[3:0]}, 4'hf);
         settle;
         chk("s1 p4", set1_port4_route, own(c[3:0]));
         chk("s1 p3", set1_port3_route, own(~c[3:0]));
         apb(0, 10'h358, 0, 0);
         chk("s1 byte", rd, {c[3:0], ~c[3:0]});
      end
   endtask
   task t_set2;
      apb(1, 10'h364, 32'h0000_0021, 4'h1);
      apb(1, 10'h368, 32'h0000_0012, 4'h1);
      apb(1, 10'h368, 32'h0000_0000, 4'he);
      settle;
      chk("s2 p12", rts[3:0], 4'h9);
      chk("s2 p34", rts[7:4], 4'h6);
   endtask
   task t_rsvd;
      logic [11:0] keep;
      keep = rts;
      foreach (rsv[i])
      begin
         apb(1, rsv[i], 32'hffff_ffff, 4'hf);
         apb(0, rsv[i], 0, 0);
         chk("spare", rd, 0);
      end
      settle;
      chk("routes kept", rts, keep);
      apb(0, 10'h000, 0, 0);
      chk("unmapped err", er, 1);
   endtask
   task final_report;
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      #100us;
      n_errors++;
      final_report;
   end
   initial
   begin
      t_reset;
      t_codes;
      t_set2;
      t_rsvd;
      t_reset;
      final_report;
   end
endmodule
bind pacr_regs pacr_regs_sva sva_chk
(
   .pclk             (pclk),
   .presetn          (presetn),
   .psel             (psel),
   .penable          (penable),
   .pwrite           (pwrite),
   .paddr            (paddr),
   .pwdata           (pwdata),
   .pstrb            (pstrb),
   .prdata           (prdata),
   .pready           (pready),
   .set1_port3_route (set1_port3_route),
   .set1_port4_route (set1_port4_route),
   .set2_port1_route (set2_port1_route),
   .set2_port2_route (set2_port2_route),
   .set2_port3_route (set2_port3_route),
   .set2_port4_route (set2_port4_route)
);
